// File: rtl/wcr_count_read.sv
`timescale 1ns/1ps
module wcr_count_read
(
    // Clock and control
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clock_en,
    // Live count words from the wakeup timer
    input wire wcr_pkg::wcr_count_t live_count,
    // Count read port strobe
    input wire logic count_port_rd,
    // Key gateway register write
    input wire logic gateway_wr,
    input wire logic [15:0] gateway_wdata,
    // Read data
    output logic [15:0] count_rd_data,
    output logic [15:0] snapshot_read_status
);

    logic [1:0] ptr_reg, ptr_next;
    logic [15:0] hold_high_reg, hold_high_next;
    logic [15:0] hold_frac_reg, hold_frac_next;
    logic [15:0] rd_data_reg, rd_data_next;
    logic key_hit;

    // Wrap skips the unused code so a stray value cannot persist
    function automatic logic [1:0] ptr_step(input logic [1:0] ptr);
        if (ptr == wcr_pkg::PTR_FRACTION)
        begin
            ptr_step = wcr_pkg::PTR_LOW;
        end
        else
        begin
            ptr_step = ptr + 2'h1;
        end
    endfunction : ptr_step

    // Reserved bits are constants, only the pointer field is live
    function automatic logic [15:0] status_word(input logic [1:0] ptr);
        logic [15:0] field;
        field = 16'(ptr) << wcr_pkg::PTR_LSB;
        status_word = (wcr_pkg::STATUS_RESET & ~wcr_pkg::PTR_FIELD_MASK)
            | (field & wcr_pkg::PTR_FIELD_MASK);
    endfunction : status_word

    assign key_hit = gateway_wr && (gateway_wdata == wcr_pkg::GATEWAY_KEY);

    always_comb
    begin
        ptr_next = ptr_reg;
        hold_high_next = hold_high_reg;
        hold_frac_next = hold_frac_reg;
        rd_data_next = rd_data_reg;
        if (count_port_rd)
        begin
            case (ptr_reg)
                wcr_pkg::PTR_LOW:
                begin
                    rd_data_next = live_count.low;
                    hold_high_next = live_count.high;
                    hold_frac_next = live_count.fraction & wcr_pkg::FRACTION_MASK;
                    ptr_next = wcr_pkg::PTR_HIGH;
                end
                wcr_pkg::PTR_HIGH:
                begin
                    rd_data_next = hold_high_reg;
                    ptr_next = wcr_pkg::PTR_FRACTION;
                end
                wcr_pkg::PTR_FRACTION:
                begin
                    rd_data_next = hold_frac_reg;
                    ptr_next = wcr_pkg::PTR_LOW;
                end
                default:
                begin
                    // Unreachable code, recover to the start
                    rd_data_next = 16'h0000;
                    ptr_next = wcr_pkg::PTR_LOW;
                end
            endcase
        end
        // key clears pointer
        // Key wins over a read in the same cycle so software restart is certain
        if (key_hit)
        begin
            ptr_next = wcr_pkg::PTR_LOW;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ptr_reg <= wcr_pkg::PTR_LOW;
            hold_high_reg <= 16'h0000;
            hold_frac_reg <= 16'h0000;
            rd_data_reg <= 16'h0000;
        end
        else if (clock_en)
        begin
            ptr_reg <= ptr_next;
            hold_high_reg <= hold_high_next;
            hold_frac_reg <= hold_frac_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign count_rd_data = rd_data_reg;

    assign snapshot_read_status = status_word(ptr_reg);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // Reads count only while the enable is high
    logic rd_go;
    assign rd_go = clock_en && count_port_rd;

    chk_first_read_low: assert property (
        rd_go && ptr_reg == wcr_pkg::PTR_LOW |=> count_rd_data == $past(live_count.low))
        else $error("First read did not return live low word");

    chk_capture_coherent: assert property (
        rd_go && ptr_reg == wcr_pkg::PTR_LOW |=> hold_high_reg == $past(live_count.high)
            && hold_frac_reg == ($past(live_count.fraction) & wcr_pkg::FRACTION_MASK))
        else $error("High and fraction not captured on first read");

    chk_second_read_high: assert property (
        rd_go && ptr_reg == wcr_pkg::PTR_HIGH |=> count_rd_data == $past(hold_high_reg))
        else $error("Second read did not return captured high word");

    chk_third_read_frac: assert property (
        rd_go && ptr_reg == wcr_pkg::PTR_FRACTION |=> count_rd_data == $past(hold_frac_reg))
        else $error("Third read did not return captured fraction word");

    chk_pointer_step: assert property (
        rd_go && !key_hit |=> ptr_reg == ptr_step($past(ptr_reg)))
        else $error("Pointer did not step on read");

    chk_first_to_high: assert property (
        rd_go && !key_hit && ptr_reg == wcr_pkg::PTR_LOW |=> ptr_reg == wcr_pkg::PTR_HIGH)
        else $error("First read did not move pointer to one");

    chk_wrap_to_zero: assert property (
        rd_go && ptr_reg == wcr_pkg::PTR_FRACTION |=> ptr_reg == wcr_pkg::PTR_LOW)
        else $error("Third read did not wrap pointer to zero");

    chk_key_clears: assert property (
        clock_en && gateway_wr && gateway_wdata == wcr_pkg::GATEWAY_KEY
            |=> ptr_reg == wcr_pkg::PTR_LOW)
        else $error("Key write did not clear pointer");

    chk_key_over_read: assert property (
        rd_go && key_hit && ptr_reg == wcr_pkg::PTR_HIGH
            |=> ptr_reg == wcr_pkg::PTR_LOW && count_rd_data == $past(hold_high_reg))
        else $error("Read with key lost its data or pointer");

    chk_idle_holds: assert property (
        !clock_en || (!count_port_rd && !gateway_wr) |=> $stable(ptr_reg)
            && $stable(hold_high_reg) && $stable(hold_frac_reg) && $stable(count_rd_data))
        else $error("State changed without a read or key");

    chk_frozen_holds: assert property (
        !clock_en |=> $stable(ptr_reg) && $stable(hold_high_reg) && $stable(hold_frac_reg)
            && $stable(count_rd_data))
        else $error("State changed while clock enable was low");

    chk_capture_first_only: assert property (
        !(rd_go && ptr_reg == wcr_pkg::PTR_LOW) |=> $stable(hold_high_reg)
            && $stable(hold_frac_reg))
        else $error("Captured words changed outside a first read");

    chk_data_holds: assert property (
        !rd_go |=> $stable(count_rd_data))
        else $error("Read data changed without a read");

    chk_pointer_field: assert property (
        snapshot_read_status[wcr_pkg::PTR_LSB +: 2] == ptr_reg && ptr_reg != 2'h3)
        else $error("Pointer field wrong or out of range");

    chk_status_step: assert property (
        rd_go && !key_hit |=> snapshot_read_status[wcr_pkg::PTR_LSB +: 2]
            == ptr_step($past(snapshot_read_status[wcr_pkg::PTR_LSB +: 2])))
        else $error("Status pointer field did not step on read");

    chk_reset_clears: assert property (
        disable iff (1'b0) sys_rst |=> ptr_reg == wcr_pkg::PTR_LOW
            && count_rd_data == 16'h0000)
        else $error("Reset did not clear pointer and read data");

    chk_status_reserved: assert property (
        (snapshot_read_status & ~wcr_pkg::PTR_FIELD_MASK) == wcr_pkg::STATUS_RESET)
        else $error("Status reserved bits wrong");

    chk_status_after_reset: assert property (
        disable iff (1'b0) sys_rst |=> snapshot_read_status == wcr_pkg::STATUS_RESET)
        else $error("Status did not read its reset value after reset");

    chk_frac_top_zero: assert property (
        rd_go && ptr_reg == wcr_pkg::PTR_FRACTION |=> count_rd_data[15] == 1'b0)
        else $error("Fraction top bit not zero");

    chk_held_frac_top: assert property (
        hold_frac_reg[15] == 1'b0)
        else $error("Captured fraction top bit not zero");

    chk_nonkey_ignored: assert property (
        clock_en && gateway_wr && gateway_wdata != wcr_pkg::GATEWAY_KEY && !count_port_rd
            |=> $stable(ptr_reg) && $stable(hold_high_reg) && $stable(hold_frac_reg))
        else $error("Non-key gateway write changed state");

endmodule : wcr_count_read

// File: rtl/wcr_pkg.sv
package wcr_pkg;
    localparam logic [31:0] SNAPSHOT_READ_STATUS_ADDR = 32'h4000_1488;
    localparam logic [15:0] STATUS_RESET = 16'h7900;
    localparam logic [15:0] GATEWAY_KEY = 16'h9376;
    localparam int PTR_LSB = 9;
    localparam logic [15:0] PTR_FIELD_MASK = 16'h0600;
    localparam logic [15:0] FRACTION_MASK = 16'h7fff;
    localparam logic [1:0] PTR_LOW = 2'h0;
    localparam logic [1:0] PTR_HIGH = 2'h1;
    localparam logic [1:0] PTR_FRACTION = 2'h2;

    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
        logic [15:0] fraction;
    } wcr_count_t;
endpackage : wcr_pkg

// File: bench/wcr_timer_model.sv
`timescale 1ns/1ps
module wcr_timer_model
(
    // Clock
    input wire logic clock,
    // Live count words
    output wcr_pkg::wcr_count_t live_count
);
    // Starts near a high word carry so captures are stressed
    logic [46:0] ticks = 47'h7fff_ffff_0000;
    // Reserved fraction bit toggles so the masking is exercised
    assign live_count = {ticks[46:31], ticks[30:15], ticks[0], ticks[14:0]};
    always @(posedge clock) ticks <= ticks + 47'h3fff;
endmodule : wcr_timer_model

// File: bench/test_wcr_count_read.sv
`timescale 1ns/1ps
module test_wcr_count_read;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clock_en = 1'b1;
    logic count_port_rd = 1'b0;
    logic gateway_wr = 1'b0;
    logic [15:0] gateway_wdata = 16'h0;
    logic [15:0] count_rd_data, snapshot_read_status, cap_h, cap_f;
    wcr_pkg::wcr_count_t live_count;
    logic [31:0] exp_q[$];
    logic [1:0] ptr = 2'h0;
    logic seen = 1'b0;
    int n_fail = 0;
    int cmp_count = 0;
    always #25 clock = ~clock;
    wcr_timer_model partner (.clock(clock), .live_count(live_count));
    wcr_count_read DUT (.clock(clock), .sys_rst(sys_rst), .clock_en(clock_en),
        .live_count(live_count), .count_port_rd(count_port_rd), .gateway_wr(gateway_wr),
        .gateway_wdata(gateway_wdata), .count_rd_data(count_rd_data),
        .snapshot_read_status(snapshot_read_status));
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        cmp_count++;
        if (got !== want)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask : check
    task automatic results();
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    // Leaves the strobe high so reads can run back to back
    // A key sent with the read clears the pointer but keeps the data
    task automatic rd(input logic with_key = 1'b0);
        logic [1:0] nxt;
        nxt = with_key ? 2'h0 : (ptr == 2'h2 ? 2'h0 : ptr + 2'h1);
        if (ptr == 2'h0)
            {cap_h, cap_f} = {live_count.high, live_count.fraction & wcr_pkg::FRACTION_MASK};
        exp_q.push_back({wcr_pkg::STATUS_RESET | {5'h0, nxt, 9'h0},
            ptr == 2'h0 ? live_count.low : ptr == 2'h1 ? cap_h : cap_f});
        ptr = nxt;
        count_port_rd = 1'b1;
        if (with_key)
        begin
            gateway_wr = 1'b1;
            gateway_wdata = wcr_pkg::GATEWAY_KEY;
        end
        @(posedge clock);
        #1;
        if (with_key)
            gateway_wr = 1'b0;
    endtask : rd
    task automatic quiet(input int n);
        count_port_rd = 1'b0;
        repeat (n) @(posedge clock);
        #1;
    endtask : quiet
    task automatic gw(input logic [15:0] val);
        gateway_wr = 1'b1;
        gateway_wdata = val;
        @(posedge clock);
        #1;
        gateway_wr = 1'b0;
        if (val == wcr_pkg::GATEWAY_KEY)
            ptr = 2'h0;
        check(snapshot_read_status, wcr_pkg::STATUS_RESET | {5'h0, ptr, 9'h0});
    endtask : gw
    always @(posedge clock) seen <= count_port_rd & clock_en & ~sys_rst;
    always @(negedge clock)
        if (seen)
        begin
            check(count_rd_data, exp_q[0][15:0]);
            check(snapshot_read_status, exp_q[0][31:16]);
            void'(exp_q.pop_front());
        end
    initial
    begin
        #100000;
        n_fail++;
        results();
    end
    initial
    begin
        void'($urandom(32'h4823));
        repeat (2) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        check(snapshot_read_status, wcr_pkg::STATUS_RESET);
        repeat (80)
        begin
            rd();
            if ($urandom_range(2) == 0)
            begin
                quiet($urandom_range(4, 1));
                gw($urandom_range(1) ? wcr_pkg::GATEWAY_KEY : 16'($urandom));
            end
        end
        quiet(2);
        gw(wcr_pkg::GATEWAY_KEY);
        rd();
        rd(1'b1);
        rd();
        quiet(1);
        // Frozen clock enable must ignore reads and keys and keep the captured words
        clock_en = 1'b0;
        count_port_rd = 1'b1;
        gateway_wr = 1'b1;
        gateway_wdata = wcr_pkg::GATEWAY_KEY;
        repeat (6) @(posedge clock);
        #1;
        clock_en = 1'b1;
        gateway_wr = 1'b0;
        rd();
        rd();
        rd();
        quiet(1);
        // Reset in mid sequence must restart the pointer
        sys_rst = 1'b1;
        @(posedge clock);
        #1;
        sys_rst = 1'b0;
        ptr = 2'h0;
        check(snapshot_read_status, wcr_pkg::STATUS_RESET);
        check(count_rd_data, 16'h0000);
        rd();
        rd();
        rd();
        quiet(3);
        results();
    end
endmodule : test_wcr_count_read
